// File: rtl/mct_translator.sv
// Micro-step current translator: step input, resolution sync and coil table
// ----------------------------------------------------------------
// Summary of operation
// - Each of 128 positions maps to fixed signed X/Y coil percentages on a circle.
// - Resolution codes 000..100 select 1/32, 1/16, 1/8, 1/4, 1/2 step.
// - Each qualifying step edge moves position one step of active resolution.
// - Polarity bit picks rising or falling step edge; the other edge does nothing.
// - Direction comes from the direction pin combined with the direction control bit.
// - Position is readable as 7 bits in 1/32 units in every mode.
// - Readable position updates right after each step trigger.
// - A new resolution takes effect only at the next step trigger.
// - Going finer snaps to the nearest position of the finer grid.
// - Going coarser on a shared position continues with zero offset.
// - Going coarser off the new grid keeps the offset while stepping.
// ----------------------------------------------------------------
module mct_translator
   import mct_pkg::*;
(
   // Clock, reset, enable
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic ce_i,
   // Pins from the controller
   input wire logic step_pulse_in_i,
   input wire logic dir_i,
   // Control bits
   input wire logic [MCT_SEL_W-1:0] step_resolution_sel_i,
   input wire logic step_edge_polarity_i,
   input wire logic rotation_ctrl_bit_i,
   // Status and coil targets
   output logic [MCT_POS_W-1:0] translator_position_o,
   output logic [MCT_SEL_W-1:0] active_resolution_o,
   output mct_coil_t coil_o
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [2:0] step_sync_r, step_sync_nxt;
   logic [2:0] dir_sync_r, dir_sync_nxt;
   logic step_lvl_r, step_lvl_nxt;
   logic dir_lvl_r, dir_lvl_nxt;
   logic trig;

   always_comb begin
      step_sync_nxt = {step_sync_r[1:0], step_pulse_in_i};
      dir_sync_nxt = {dir_sync_r[1:0], dir_i};
      step_lvl_nxt = step_lvl_r;
      dir_lvl_nxt = dir_lvl_r;
      // Only stages two and three are compared, so a glitch must last two clocks
      if (step_sync_r[1] == step_sync_r[2]) begin
         step_lvl_nxt = step_sync_r[2];
      end
      if (dir_sync_r[1] == dir_sync_r[2]) begin
         dir_lvl_nxt = dir_sync_r[2];
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         step_sync_r <= 3'h0;
         dir_sync_r <= 3'h0;
         step_lvl_r <= 1'b0;
         dir_lvl_r <= 1'b0;
      end else if (ce_i) begin
         step_sync_r <= step_sync_nxt;
         dir_sync_r <= dir_sync_nxt;
         step_lvl_r <= step_lvl_nxt;
         dir_lvl_r <= dir_lvl_nxt;
      end
   end

   // Rising edge when polarity is 0, falling edge when it is 1
   assign trig = ce_i && (step_lvl_nxt != step_lvl_r) &&
                 (step_lvl_nxt == !step_edge_polarity_i);

   // ----------------------------------------------------------------
   // Translator position and resolution
   // ----------------------------------------------------------------
   logic [MCT_POS_W-1:0] pos_r, pos_nxt;
   logic [MCT_SEL_W-1:0] res_r, res_nxt;
   logic [MCT_POS_W-1:0] base;
   logic [MCT_POS_W-1:0] stp;
   logic sel_legal;
   logic step_up;
   mct_change_t change;

   assign sel_legal = (step_resolution_sel_i <= MCT_RES_2);
   assign step_up = !(dir_lvl_r ^ rotation_ctrl_bit_i);

   always_comb begin
      res_nxt = res_r;
      pos_nxt = pos_r;
      base = pos_r;
      change = MCT_KEEP;
      // Codes above half step are ignored and the old resolution stays
      if (trig && sel_legal) begin
         res_nxt = step_resolution_sel_i;
      end
      if (res_nxt < res_r) begin
         change = MCT_FINER;
      end else if (res_nxt > res_r) begin
         change = MCT_COARSER;
      end
      stp = mct_step(res_nxt);
      unique case (change)
         MCT_FINER: begin
            // Round to nearest point of the finer grid, halves round up
            base = (pos_r + (stp >> 1)) & ~mct_mask(res_nxt);
         end
         MCT_COARSER: begin
            // Offset is kept; zero offset falls out when on the shared grid
            base = pos_r;
         end
         MCT_KEEP: begin
            base = pos_r;
         end
      endcase
      if (trig) begin
         // 7-bit arithmetic wraps modulo 128
         pos_nxt = step_up ? base + stp : base - stp;
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pos_r <= MCT_POS_RST;
         res_r <= MCT_RES_32;
      end else if (ce_i) begin
         pos_r <= pos_nxt;
         res_r <= res_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Coil current lookup
   // ----------------------------------------------------------------
   // Sine over 128 positions built from one quarter wave
   function automatic logic signed [MCT_CUR_W-1:0] mct_wave(input logic [MCT_POS_W-1:0] a);
      logic [5:0] idx;
      logic [MCT_MAG_W-1:0] mag;
      idx = a[5] ? {1'b0, a[4:0]} : 6'(MCT_QUARTER - {1'b0, a[4:0]});
      mag = MCT_QTAB[idx];
      return a[6] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
   endfunction

   mct_coil_t coil_r, coil_nxt;

   always_comb begin
      coil_nxt.x = mct_wave(pos_nxt);
      coil_nxt.y = mct_wave(pos_nxt + 7'(MCT_QUARTER));
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         coil_r <= '{x: '0, y: 11'(MCT_QTAB[0])};
      end else if (ce_i) begin
         coil_r <= coil_nxt;
      end
   end

   // Position and coils leave flops and change together on the clock edge after the trigger
   assign translator_position_o = pos_r;
   assign active_resolution_o = res_r;
   assign coil_o = coil_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_coil_at_quarter: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (pos_r == 7'h60) |-> (coil_r.x == -11'sh3E8) && (coil_r.y == 11'sh000))
      else $error("coil currents wrong at position 96");

   a_coil_circle_sym: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (pos_r == 7'h20) |-> (coil_r.x == 11'sh3E8) && (coil_r.y == 11'sh000))
      else $error("coil currents wrong at position 32");

   a_mode_hold_idle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !trig |=> $stable(res_r))
      else $error("resolution changed without a step trigger");

   a_mode_takes_effect: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (trig && sel_legal) |=> (res_r == $past(step_resolution_sel_i)))
      else $error("resolution not applied at step trigger");

   a_pos_still_idle: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      !trig |=> $stable(pos_r))
      else $error("position moved without a trigger");

   a_step_same_res: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (trig && sel_legal && step_resolution_sel_i == res_r) |=>
      (pos_r == ($past(step_up) ? $past(pos_r) + mct_step(res_r) : $past(pos_r) - mct_step(res_r))))
      else $error("step size or direction wrong");

   a_wrap_up: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (trig && step_up && pos_r == 7'h7F && res_nxt == MCT_RES_32) |=> (pos_r == 7'h00))
      else $error("position did not wrap to 0");

   a_finer_on_grid: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (trig && sel_legal && step_resolution_sel_i < res_r) |=> ((pos_r & mct_mask(res_r)) == 7'h00))
      else $error("finer resolution left position off grid");

   a_coarse_offset: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (trig && sel_legal && step_resolution_sel_i > res_r) |=>
      (((pos_r ^ $past(pos_r)) & mct_mask(res_r)) == 7'h00))
      else $error("coarser resolution lost its offset");

   a_coarse_shared: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (trig && sel_legal && step_resolution_sel_i > res_r &&
       ((pos_r & mct_mask(step_resolution_sel_i)) == 7'h00)) |=>
      ((pos_r & mct_mask(res_r)) == 7'h00))
      else $error("coarser resolution on a shared position gained an offset");

   a_trig_edge_pol: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      trig |=> (step_lvl_r == !$past(step_edge_polarity_i)))
      else $error("trigger on wrong edge");

   a_dir_down: assert property (@(posedge clock_i) disable iff (!rst_n_i)
      (trig && (dir_lvl_r ^ rotation_ctrl_bit_i) && res_nxt == res_r) |=>
      (pos_r == $past(pos_r) - mct_step(res_r)))
      else $error("direction combination ignored");

endmodule

// File: rtl/mct_pkg.sv
// Package for the micro-step current translator: widths, modes, coil table
package mct_pkg;

   // ----------------------------------------------------------------
   // Widths and reset values
   // ----------------------------------------------------------------
   localparam int MCT_POS_W = 7;
   localparam int MCT_SEL_W = 3;
   localparam int MCT_CUR_W = 11;
   localparam int MCT_MAG_W = 10;
   localparam logic [MCT_POS_W-1:0] MCT_POS_RST = 7'h00;
   localparam logic [MCT_POS_W-1:0] MCT_POS_ONE = 7'h01;
   localparam logic [5:0] MCT_QUARTER = 6'h20;

   // ----------------------------------------------------------------
   // Step resolution codes (value equals log2 of the step in 1/32 units)
   // ----------------------------------------------------------------
   localparam logic [MCT_SEL_W-1:0] MCT_RES_32 = 3'h0;
   localparam logic [MCT_SEL_W-1:0] MCT_RES_16 = 3'h1;
   localparam logic [MCT_SEL_W-1:0] MCT_RES_8 = 3'h2;
   localparam logic [MCT_SEL_W-1:0] MCT_RES_4 = 3'h3;
   localparam logic [MCT_SEL_W-1:0] MCT_RES_2 = 3'h4;

   // ----------------------------------------------------------------
   // Quarter wave of coil current, tenths of a percent of peak
   // ----------------------------------------------------------------
   localparam logic [MCT_MAG_W-1:0] MCT_QTAB [0:32] = '{
      10'h3E8, 10'h3DC, 10'h3D1, 10'h3C5, 10'h3B9, 10'h3AD, 10'h3A2, 10'h396,
      10'h37F, 10'h368, 10'h351, 10'h33A, 10'h316, 10'h2F3, 10'h2D1, 10'h2AE,
      10'h28B, 10'h268, 10'h245, 10'h222, 10'h1F4, 10'h1D1, 10'h1AE, 10'h17F,
      10'h15D, 10'h13A, 10'h10B, 10'h0DD, 10'h0AE, 10'h07F, 10'h051, 10'h023,
      10'h000};

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic signed [MCT_CUR_W-1:0] x;
      logic signed [MCT_CUR_W-1:0] y;
   } mct_coil_t;

   typedef enum logic [1:0] {
      MCT_KEEP,
      MCT_FINER,
      MCT_COARSER
   } mct_change_t;

   // Step size in 1/32 units for a resolution code
   function automatic logic [MCT_POS_W-1:0] mct_step(input logic [MCT_SEL_W-1:0] res);
      return MCT_POS_ONE << res;
   endfunction

   // Bits below the grid of a resolution code
   function automatic logic [MCT_POS_W-1:0] mct_mask(input logic [MCT_SEL_W-1:0] res);
      return (MCT_POS_ONE << res) - MCT_POS_ONE;
   endfunction

endpackage

// File: test/mct_ctrl_model.sv
// Controller model that drives the step and direction pins
module mct_ctrl_model (
   // Clock
   input wire logic clock_i,
   // Pins towards the translator
   output logic step_pulse_in_o,
   output logic dir_o
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      step_pulse_in_o = 1'h0;
      dir_o = 1'h0;
   end

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   // Direction is set first so the filtered pin is stable at the trigger
   task automatic put(input logic lvl, input logic dir);
      @(posedge clock_i);
      #2;
      dir_o = dir;
      repeat (4) @(posedge clock_i);
      #2;
      // Each phase lasts at least 8 clocks, well above the filter's minimum
      step_pulse_in_o = lvl;
      repeat (8) @(posedge clock_i);
   endtask

   task automatic pulse(input logic dir);
      put(1'h1, dir);
      put(1'h0, dir);
   endtask
endmodule

// File: test/microstep_current_translator_bench.sv
// Self-checking bench for the micro-step current translator
module microstep_current_translator_bench
   import mct_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic clock_i;
   logic rst_n_i;
   logic ce_i;
   logic step_w;
   logic dir_w;
   logic [MCT_SEL_W-1:0] sel;
   logic pol;
   logic ctrl;
   logic [MCT_POS_W-1:0] pos;
   logic [MCT_SEL_W-1:0] ares;
   mct_coil_t coil;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   // Sequence of resolution codes, directions and resulting positions
   // Steps 6 to 8 go coarser only on positions shared with the new grid
   localparam logic [2:0] TS [15] = '{3'h4, 3'h4, 3'h2, 3'h1, 3'h0, 3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h4,
      3'h4, 3'h4, 3'h4, 3'h4};
   localparam logic TD [15] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0,
      1'h0, 1'h0, 1'h0, 1'h0};
   localparam logic [6:0] TP [15] = '{7'h11, 7'h21, 7'h24, 7'h26, 7'h27, 7'h26, 7'h28, 7'h30, 7'h40, 7'h50, 7'h60,
      7'h70, 7'h00, 7'h10, 7'h20};

   mct_translator u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .step_pulse_in_i(step_w),
      .dir_i(dir_w), .step_resolution_sel_i(sel), .step_edge_polarity_i(pol), .rotation_ctrl_bit_i(ctrl),
      .translator_position_o(pos), .active_resolution_o(ares), .coil_o(coil));
   mct_ctrl_model u_ctrl (.clock_i(clock_i), .step_pulse_in_o(step_w), .dir_o(dir_w));

   initial begin
      clock_i = 1'h0;
      forever #12.5 clock_i = ~clock_i;
   end

   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s expected %0d seen %0d", name, exp, seen);
      end
   endtask

   task automatic chk_coil(input logic signed [10:0] x, input logic signed [10:0] y);
      chk("coil x", 32'(coil.x), 32'(x));
      chk("coil y", 32'(coil.y), 32'(y));
   endtask

   task automatic stop_test();
      $display("Comparisons %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Ceiling well above the roughly 510 clocks the scenarios need
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         stop_test();
      end
   end

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic s_reset();
      chk("position", 32'(pos), 32'h0);
      chk("resolution", 32'(ares), 32'(MCT_RES_32));
      chk_coil(11'sh000, 11'sh3E8);
   endtask

   task automatic s_dir_wrap();
      u_ctrl.pulse(1'h1);
      chk("position", 32'(pos), 32'h7F);
      chk_coil(-11'sh023, 11'sh3DC);
      #2;
      ctrl = 1'h1;
      u_ctrl.pulse(1'h1);
      chk("position", 32'(pos), 32'h0);
   endtask

   task automatic s_polarity();
      #2;
      ctrl = 1'h0;
      pol = 1'h1;
      u_ctrl.put(1'h1, 1'h0);
      chk("position", 32'(pos), 32'h0);
      u_ctrl.put(1'h0, 1'h0);
      chk("position", 32'(pos), 32'h1);
      #2;
      pol = 1'h0;
   endtask

   // A pulse while the clock enable is low must leave no trace
   task automatic s_freeze();
      #2;
      ce_i = 1'h0;
      u_ctrl.pulse(1'h0);
      chk("position", 32'(pos), 32'h1);
      #2;
      ce_i = 1'h1;
      repeat (4) @(posedge clock_i);
      chk("position", 32'(pos), 32'h1);
   endtask

   task automatic s_res_sync();
      #2;
      sel = MCT_RES_2;
      repeat (3) @(posedge clock_i);
      chk("resolution", 32'(ares), 32'(MCT_RES_32));
      chk("position", 32'(pos), 32'h1);
      // Covers off-grid coarser, finer snaps, shared coarser, an illegal code and a half-step wrap
      for (int i = 0; i < 15; i++) begin
         #2;
         sel = TS[i];
         u_ctrl.pulse(TD[i]);
         chk("position", 32'(pos), 32'(TP[i]));
         chk("resolution", 32'(ares), 32'((TS[i] > MCT_RES_2) ? MCT_RES_2 : TS[i]));
         if (i == 10) begin
            chk_coil(-11'sh3E8, 11'sh000);
         end
      end
      chk_coil(11'sh3E8, 11'sh000);
   endtask

   initial begin
      rst_n_i = 1'h0;
      ce_i = 1'h1;
      sel = MCT_RES_32;
      pol = 1'h0;
      ctrl = 1'h0;
      repeat (4) @(posedge clock_i);
      #2;
      rst_n_i = 1'h1;
      @(posedge clock_i);
      #2;
      s_reset();
      s_dir_wrap();
      s_polarity();
      s_freeze();
      s_res_sync();
      stop_test();
   end
endmodule
